// file: logic/iac_ctrl.sv
// injected-channel trigger, start bit, interrupts and any-channel control
// assumes the analog core reports sample/conversion/sequence ends as pulses
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
`include "iac_defines.svh"
module iac_ctrl import iac_pkg::*; (
    input  wire logic        pclk,          // 20 MHz bus clock
    input  wire logic        presetn,       // async reset
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb enable
    input  wire logic        pwrite,        // apb direction
    input  wire logic [11:0] paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error
    input  wire logic [17:0] trig_in,       // hardware trigger lines by source code
    input  wire logic        scan_active,   // core in one-cycle/continuous scan
    input  wire logic        last_ch_start, // core starts last channel
    input  wire logic        samp_end,      // end of sampling pulse
    input  wire logic        conv_end,      // end of conversion pulse
    input  wire logic        seq_end,       // end of sequence pulse
    output logic             sample_go,     // start sampling pulse to core
    output logic             inj_busy,      // injected sequence in progress
    output logic             auto_conv,     // automatic injected conversion
    output logic             anychan_mode,  // working any-channel enable
    output logic             src_invalid,   // selected source code invalid
    output logic             irq            // interrupt level
);
    iac_ctrl_t  ctrl_r;
    iac_state_t state_r;
    logic [9:0] dly_cnt_r;
    logic       trig_d_r;
    logic       any_work_r;
    logic [2:0] stat_r;
    logic [2:0] mask_r;
    logic       wr, rd, trig_lvl, trig_evt, sw_go, hw_go;
    logic [2:0] ev;

    // the step from 4 to 16 breaks the doubling pattern, so a table is safer than a shift
    function automatic logic [9:0] delay_cycles(input logic [2:0] c);
        case (c)
            3'h1:    delay_cycles = `IAC_DLY_C1;
            3'h2:    delay_cycles = `IAC_DLY_C2;
            3'h3:    delay_cycles = `IAC_DLY_C3;
            3'h4:    delay_cycles = `IAC_DLY_C4;
            3'h5:    delay_cycles = `IAC_DLY_C5;
            3'h6:    delay_cycles = `IAC_DLY_C6;
            3'h7:    delay_cycles = `IAC_DLY_C7;
            default: delay_cycles = 10'h000;
        endcase
    endfunction : delay_cycles

    function automatic logic src_ok(input logic [4:0] s);
        case (s)
            5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h07, 5'h08, 5'h09,
            5'h0A, 5'h0B, 5'h0D, 5'h0F, 5'h10, 5'h11: src_ok = 1'b1;
            default:                                   src_ok = 1'b0;
        endcase
    endfunction : src_ok

    assign wr      = psel & penable & pwrite;
    assign rd      = psel & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // source 00101 merges the two compare outputs on lines 16 and 17
    always_comb begin
        trig_lvl = 1'b0;
        if (ctrl_r.src_sel == 5'h05) begin
            trig_lvl = trig_in[16] | trig_in[17];
        end else if (src_ok(ctrl_r.src_sel)) begin
            trig_lvl = trig_in[ctrl_r.src_sel];
        end
    end
    assign src_invalid = ~src_ok(ctrl_r.src_sel);

    always_comb begin
        case (ctrl_r.edge_sel)
            `IAC_EDGE_BOTH: trig_evt = trig_lvl ^ trig_d_r;
            `IAC_EDGE_FALL: trig_evt = ~trig_lvl & trig_d_r;
            `IAC_EDGE_RISE: trig_evt = trig_lvl & ~trig_d_r;
            default:        trig_evt = 1'b0;
        endcase
    end

    assign hw_go = trig_evt & ctrl_r.hw_trig_en & ctrl_r.conv_en & ~src_invalid;
    assign sw_go = wr && paddr == `IAC_CTRL_OFF && pwdata[`IAC_BIT_START] && ctrl_r.conv_en
                   && !ctrl_r.conv_start;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_d_r <= 1'b0;
        end else begin
            trig_d_r <= trig_lvl;
        end
    end

    // sequencer: only the first sample of a sequence waits out the delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= IAC_IDLE;
            dly_cnt_r <= 10'h000;
        end else if (!ctrl_r.conv_en) begin
            state_r   <= IAC_IDLE;
        end else begin
            case (state_r)
                IAC_IDLE: begin
                    if (hw_go) begin
                        dly_cnt_r <= delay_cycles(ctrl_r.delay_sel);
                        state_r   <= IAC_DELAY;
                    end else if (sw_go) begin
                        dly_cnt_r <= 10'h000;
                        state_r   <= IAC_DELAY;
                    end
                end
                IAC_DELAY: begin
                    if (dly_cnt_r == 10'h000) begin
                        state_r <= IAC_RUN;
                    end else begin
                        dly_cnt_r <= dly_cnt_r - 10'h001;
                    end
                end
                IAC_RUN: begin
                    if (seq_end) begin
                        state_r <= IAC_IDLE;
                    end
                end
                default: state_r <= IAC_IDLE;
            endcase
        end
    end

    assign sample_go = (state_r == IAC_DELAY) && (dly_cnt_r == 10'h000);
    assign inj_busy  = (state_r != IAC_IDLE);
    assign auto_conv = ctrl_r.auto_conv;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `IAC_CTRL_RESET;
        end else begin
            if (wr && paddr == `IAC_CTRL_OFF) begin
                ctrl_r <= iac_ctrl_t'(pwdata & `IAC_CTRL_WMASK);
            end
            if (hw_go) begin
                ctrl_r.conv_start <= 1'b1;
            end
            if (seq_end && state_r == IAC_RUN) begin
                ctrl_r.conv_start <= 1'b0;
            end
            if (!ctrl_r.conv_en || (wr && paddr == `IAC_CTRL_OFF && !pwdata[1])) begin
                ctrl_r.conv_start <= 1'b0;
            end
        end
    end

    // working any-channel enable follows the shadow outside scans and at the last channel start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            any_work_r <= 1'b0;
        end else if (!scan_active || last_ch_start) begin
            any_work_r <= ctrl_r.anychan_en;
        end
    end
    assign anychan_mode = any_work_r;

    assign ev = {seq_end, conv_end, samp_end} & {3{state_r == IAC_RUN}};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= 3'h0;
            mask_r <= 3'h0;
        end else begin
            if (wr && paddr == `IAC_MASK_OFF) begin
                mask_r <= pwdata[2:0];
            end
            if (wr && paddr == `IAC_STAT_OFF) begin
                stat_r <= (stat_r & ~pwdata[2:0]) | ev;
            end else begin
                stat_r <= stat_r | ev;
            end
        end
    end

    // status bits 2:0 are seq, conv, sample; enables come from the control word
    assign irq = |(stat_r & mask_r & {ctrl_r.eos_ie, ctrl_r.eoc_ie, ctrl_r.eosmp_ie});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd && !penable) begin
            case (paddr)
                `IAC_CTRL_OFF: prdata <= ctrl_r;
                `IAC_STAT_OFF: prdata <= {29'h0000_0000, stat_r};
                `IAC_MASK_OFF: prdata <= {29'h0000_0000, mask_r};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end

    property p_start_clr;
        @(posedge pclk) disable iff (!presetn)
        !ctrl_r.conv_en |=> !ctrl_r.conv_start;
    endproperty
    a_start_clr: assert property (p_start_clr) else $error("start bit not cleared");

    property p_done_clr;
        @(posedge pclk) disable iff (!presetn)
        (seq_end && state_r == IAC_RUN && !hw_go) |=> !ctrl_r.conv_start;
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("start bit kept after done");

    property p_block;
        @(posedge pclk) disable iff (!presetn)
        ctrl_r.edge_sel == `IAC_EDGE_BLOCK |-> !hw_go;
    endproperty
    a_block: assert property (p_block) else $error("blocked trigger accepted");

    property p_trig_en;
        @(posedge pclk) disable iff (!presetn)
        !ctrl_r.hw_trig_en |-> !hw_go;
    endproperty
    a_trig_en: assert property (p_trig_en) else $error("trigger taken while disabled");

    property p_delay4;
        @(posedge pclk) disable iff (!presetn)
        (state_r == IAC_IDLE && hw_go && ctrl_r.delay_sel == 3'h1 && ctrl_r.conv_en)
        |=> !sample_go [*4] ##1 (sample_go || !ctrl_r.conv_en);
    endproperty
    a_delay4: assert property (p_delay4) else $error("delay of 4 wrong");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        irq |-> |({ctrl_r.eos_ie, ctrl_r.eoc_ie, ctrl_r.eosmp_ie} & stat_r);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without enabled flag");

    property p_shadow;
        @(posedge pclk) disable iff (!presetn)
        (scan_active && !last_ch_start) |=> $stable(any_work_r);
    endproperty
    a_shadow: assert property (p_shadow) else $error("any-channel changed mid scan");

    property p_invalid;
        @(posedge pclk) disable iff (!presetn)
        src_invalid |-> !hw_go;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid source triggered");

    // edge qualification seen from the accepted trigger back to the selected line
    property p_fall;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_r.edge_sel == `IAC_EDGE_FALL && hw_go) |-> (!trig_lvl && trig_d_r);
    endproperty
    a_fall: assert property (p_fall) else $error("falling edge mode took other edge");

    property p_rise;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_r.edge_sel == `IAC_EDGE_RISE && hw_go) |-> (trig_lvl && !trig_d_r);
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge mode took other edge");

    property p_both;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_r.edge_sel == `IAC_EDGE_BOTH && hw_go) |-> (trig_lvl != trig_d_r);
    endproperty
    a_both: assert property (p_both) else $error("double edge mode took no edge");

    property p_sw_nodelay;
        @(posedge pclk) disable iff (!presetn)
        (state_r == IAC_IDLE && sw_go && !hw_go) |=> sample_go;
    endproperty
    a_sw_nodelay: assert property (p_sw_nodelay) else $error("software start delayed");

    property p_dly_load;
        @(posedge pclk) disable iff (!presetn)
        (state_r == IAC_IDLE && hw_go) |=> dly_cnt_r == delay_cycles($past(ctrl_r.delay_sel));
    endproperty
    a_dly_load: assert property (p_dly_load) else $error("delay count loaded wrong");

    property p_dly_count;
        @(posedge pclk) disable iff (!presetn)
        (state_r == IAC_DELAY && dly_cnt_r != 10'h000 && ctrl_r.conv_en)
        |=> dly_cnt_r == $past(dly_cnt_r) - 10'h001;
    endproperty
    a_dly_count: assert property (p_dly_count) else $error("delay count skipped");

    // later channels are paced by the core, never by this delay
    property p_run_nodelay;
        @(posedge pclk) disable iff (!presetn)
        (state_r == IAC_RUN) |-> !sample_go;
    endproperty
    a_run_nodelay: assert property (p_run_nodelay) else $error("second delayed start");

    property p_run_exit;
        @(posedge pclk) disable iff (!presetn)
        (state_r == IAC_RUN && seq_end) |=> state_r == IAC_IDLE;
    endproperty
    a_run_exit: assert property (p_run_exit) else $error("sequence end not seen");

    property p_idle_hold;
        @(posedge pclk) disable iff (!presetn)
        (state_r == IAC_IDLE && !hw_go && !sw_go) |=> state_r == IAC_IDLE;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("start without request");

    property p_auto_wr;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `IAC_CTRL_OFF) |=> auto_conv == $past(pwdata[5]);
    endproperty
    a_auto_wr: assert property (p_auto_wr) else $error("auto conversion bit lost");

    property p_ie_off;
        @(posedge pclk) disable iff (!presetn)
        (!ctrl_r.eos_ie && !ctrl_r.eoc_ie && !ctrl_r.eosmp_ie) |-> !irq;
    endproperty
    a_ie_off: assert property (p_ie_off) else $error("irq with all enables off");

    property p_eos_irq;
        @(posedge pclk) disable iff (!presetn)
        (stat_r[2] && mask_r[2] && ctrl_r.eos_ie) |-> irq;
    endproperty
    a_eos_irq: assert property (p_eos_irq) else $error("sequence irq missing");

    property p_eoc_irq;
        @(posedge pclk) disable iff (!presetn)
        (stat_r[1] && mask_r[1] && ctrl_r.eoc_ie) |-> irq;
    endproperty
    a_eoc_irq: assert property (p_eoc_irq) else $error("conversion irq missing");

    property p_eosmp_irq;
        @(posedge pclk) disable iff (!presetn)
        (stat_r[0] && mask_r[0] && ctrl_r.eosmp_ie) |-> irq;
    endproperty
    a_eosmp_irq: assert property (p_eosmp_irq) else $error("sampling irq missing");

    property p_en_idle;
        @(posedge pclk) disable iff (!presetn)
        !ctrl_r.conv_en |=> state_r == IAC_IDLE;
    endproperty
    a_en_idle: assert property (p_en_idle) else $error("sequencer ran while disabled");

    property p_any_free;
        @(posedge pclk) disable iff (!presetn)
        !scan_active |=> anychan_mode == $past(ctrl_r.anychan_en);
    endproperty
    a_any_free: assert property (p_any_free) else $error("mode enable not applied");

    property p_any_last;
        @(posedge pclk) disable iff (!presetn)
        last_ch_start |=> anychan_mode == $past(ctrl_r.anychan_en);
    endproperty
    a_any_last: assert property (p_any_last) else $error("shadow not moved at last channel");

    // set must win over a clear written in the same cycle
    property p_stat_set;
        @(posedge pclk) disable iff (!presetn)
        ev[0] |=> stat_r[0];
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("sampling flag lost");
endmodule : iac_ctrl

// file: logic/iac_defines.svh
// constants for the injected-channel and any-channel control block
// assumes apb byte addressing with 32-bit data
// Contract
// - edge field 00 both, 01 falling, 10 rising, 11 blocks triggers
// - delay field 000 none, else 4,16,32,64,128,256,512 pclk cycles before sampling
// - only first channel of a triggered scan waits for the delay
// - five-bit source select from fixed codes; other codes are invalid
// - hardware triggers start injected conversion only when trigger enable set
// - software sets start after enabling; bit reads 0 when done or idle
// - hardware clears start bit when injected conversion completes
// - start bit forced to 0 while conversion enable is 0, and by reset
// - auto-conversion bit turns automatic injected conversion on or off
// - end-of-sequence request raised only when its enable is set
// - end-of-conversion request raised only when its enable is set
// - end-of-sampling request raised only when its enable is set
// - conversion enable allows injected conversions when set
// - bit 0 enables any-channel mode
// - during scan any-channel writes go to shadow, copied at last channel start
`ifndef IAC_DEFINES_SVH
`define IAC_DEFINES_SVH
`define IAC_CTRL_OFF     12'h068
`define IAC_STAT_OFF     12'h06C
`define IAC_MASK_OFF     12'h070
`define IAC_CTRL_RESET   32'h0000_0000
`define IAC_CTRL_WMASK   32'h0003_FFFF
`define IAC_EDGE_BOTH    2'h0
`define IAC_EDGE_FALL    2'h1
`define IAC_EDGE_RISE    2'h2
`define IAC_EDGE_BLOCK   2'h3
`define IAC_SRC_MAX      5'h11
`define IAC_BIT_START    6
`define IAC_BIT_ANYEN    0
`define IAC_DLY_C1       10'h004
`define IAC_DLY_C2       10'h010
`define IAC_DLY_C3       10'h020
`define IAC_DLY_C4       10'h040
`define IAC_DLY_C5       10'h080
`define IAC_DLY_C6       10'h100
`define IAC_DLY_C7       10'h200
`endif

// file: logic/iac_pkg.sv
// types for the injected-channel and any-channel control block
// assumes iac_defines.svh is available for the numbers
package iac_pkg;
    typedef struct packed {
        logic [13:0] rsvd;
        logic [1:0]  edge_sel;
        logic [2:0]  delay_sel;
        logic [4:0]  src_sel;
        logic        hw_trig_en;
        logic        conv_start;
        logic        auto_conv;
        logic        eos_ie;
        logic        eoc_ie;
        logic        eosmp_ie;
        logic        conv_en;
        logic        anychan_en;
    } iac_ctrl_t;
    typedef enum logic [1:0] {
        IAC_IDLE  = 2'b00,
        IAC_DELAY = 2'b01,
        IAC_RUN   = 2'b10
    } iac_state_t;
endpackage : iac_pkg

// file: testbench/test_iac_ctrl.sv
// self-checking bench for the injected-channel and any-channel control block
// assumes zero-wait apb slave and one-cycle event pulses driven by this bench
`timescale 1ns/100ps
`include "iac_defines.svh"
module test_iac_ctrl import iac_pkg::*;;
    logic        pclk, presetn, psel, penable, pwrite, scan_active;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, sample_go, inj_busy, auto_conv, anychan_mode, src_invalid, irq;
    logic [17:0] trig_in;
    logic [3:0]  ev;
    int          err_count, samples_checked, cyc, n, base, c;
    int          dly [8] = '{0, 4, 16, 32, 64, 128, 256, 512};

    iac_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_in(trig_in), .scan_active(scan_active),
        .last_ch_start(ev[3]), .samp_end(ev[0]), .conv_end(ev[1]), .seq_end(ev[2]),
        .sample_go(sample_go), .inj_busy(inj_busy), .auto_conv(auto_conv),
        .anychan_mode(anychan_mode), .src_invalid(src_invalid), .irq(irq));

    always #25 pclk = ~pclk;

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // the request is released at the pready edge, then one idle cycle separates calls
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        chk("pslverr", 0, pslverr);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
    endtask : pulse

    task automatic trig(input int i, input logic v);
        @(posedge pclk);
        trig_in[i] <= v;
    endtask : trig

    // counts negedges until sample_go; n equals lim when it never came
    task automatic wait_go(input int lim);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (sample_go !== 1'b1 && n < lim);
    endtask : wait_go

    task automatic edge_try(input int i, input logic v, input logic e);
        trig(i, v);
        wait_go(20);
        chk("trigger seen", e, n < 20);
        if (n < 20) pulse(2);
    endtask : edge_try

    initial begin
        {pclk, presetn, psel, penable, pwrite, scan_active, paddr, pwdata, trig_in, ev} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `IAC_CTRL_OFF, 0);
        chk("ctrl reset", `IAC_CTRL_RESET, q);
        apb(1, `IAC_CTRL_OFF, 32'h0003_FFFF);
        apb(0, `IAC_CTRL_OFF, 0);
        chk("ctrl rw", 32'h0003_FFBF, q);
        chk("mode", 1, {auto_conv, anychan_mode} == 2'h3);
        apb(0, 12'h07C, 0);
        chk("unmapped", 0, q);
        apb(1, `IAC_CTRL_OFF, 32'h0000_0002);
        apb(1, `IAC_CTRL_OFF, 32'h0000_0042);
        chk("sw go", 1, sample_go | inj_busy);
        apb(0, `IAC_CTRL_OFF, 0);
        chk("start set", 32'h0000_0042, q);
        pulse(2);
        apb(0, `IAC_CTRL_OFF, 0);
        chk("auto clear", 32'h0000_0002, q);
        apb(1, `IAC_CTRL_OFF, 32'h0000_0042);
        apb(1, `IAC_CTRL_OFF, 32'h0000_0040);
        apb(0, `IAC_CTRL_OFF, 0);
        chk("forced clear", 0, q);
        for (c = 0; c < 8; c++) begin
            apb(1, `IAC_CTRL_OFF, 32'h0002_0082 | (c << 13));
            trig(0, 1'b1);
            wait_go(700);
            if (c == 0) base = n;
            else chk("delay", dly[c], n - base);
            pulse(2);
            trig(0, 1'b0);
        end
        for (c = 0; c < 4; c++) begin
            apb(1, `IAC_CTRL_OFF, 32'h0000_0082 | (c << 16));
            edge_try(0, 1'b1, c == 0 || c == 2);
            edge_try(0, 1'b0, c < 2);
        end
        apb(1, `IAC_CTRL_OFF, 32'h0002_0002);
        edge_try(0, 1'b1, 1'b0);
        trig(0, 1'b0);
        apb(1, `IAC_CTRL_OFF, 32'h0002_0582);
        edge_try(17, 1'b1, 1'b1);
        for (c = 0; c < 32; c++) begin
            apb(1, `IAC_CTRL_OFF, c << 8);
            chk("src invalid", !(32'h0003_AFAF >> c & 1), src_invalid);
        end
        for (c = 0; c < 3; c++) begin
            apb(1, `IAC_CTRL_OFF, 32'h0000_0002 | (4 << c));
            apb(1, `IAC_MASK_OFF, 1 << c);
            apb(1, `IAC_CTRL_OFF, 32'h0000_0042 | (4 << c));
            pulse(c);
            pulse(2);
            apb(0, `IAC_STAT_OFF, 0);
            chk("status", (1 << c) | 4, q);
            chk("irq on", 1, irq);
            apb(1, `IAC_CTRL_OFF, 32'h0000_0002);
            chk("irq ie off", 0, irq);
            apb(1, `IAC_CTRL_OFF, 32'h0000_0002 | (4 << c));
            apb(1, `IAC_STAT_OFF, 32'h0000_0007);
            chk("irq cleared", 0, irq);
        end
        scan_active <= 1'b1;
        apb(1, `IAC_CTRL_OFF, 32'h0000_0001);
        chk("shadow held", 0, anychan_mode);
        pulse(3);
        @(negedge pclk);
        chk("shadow moved", 1, anychan_mode);
        scan_active <= 1'b0;
        apb(1, `IAC_CTRL_OFF, 32'h0000_0000);
        @(negedge pclk);
        chk("mode off", 0, anychan_mode);
        end_of_test();
    end
endmodule : test_iac_ctrl
